// ==== psef_top.sv ====
// Purpose: sensor-side link supervisor: init phases, fault codes, programming entry
// Assumes: sync_pulse / sync_miss mark each sync slot; command decoder sits outside
// Notes: framing, stuffing and crc are checked by the decoder, reported via cmd_ok
//
// Overview of operation
// - supply fault in phase 2 makes sync pulses go unanswered until it clears.
// - temperature or memory fault in phase 2 still sends phase 2 frames.
// - blocking fault holds phase 2; remaining frames finish afterwards, then phase 3.
// - supply fault in phase 3 makes sync pulses go unanswered meanwhile.
// - temperature or memory fault in phase 3 still sends phase 3 frames.
// - blocking fault in phase 3 bars run mode; remaining ready frames finish after it clears.
// - unprogrammed second fuse region sends ready-but-not-locked instead of ready.
// - communication fault reports code 1EF, rank 6.
// - enabled test mode reports code 1EE, rank 2.
// - pressure out of range reports code 1ED, rank 5.
// - temperature fault reports code 1EC, rank 4.
// - self-test fault reports code 1EA, rank 1, latched until reset.
// - one error frame clears a non-latched fault; data resumes once it is gone.
// - supply fault in normal mode gives no code; output pauses, then resumes.
// - entry needs 31 or more syncs right before the entry command, in window.
// - window passing without entry blocks programming entry until reset.
// - after failed entry, run phases 2 and 3, then normal mode.
// - in programming mode no normal frames answer sync pulses.
// - in programming mode, commands are decoded only after a start condition.
// - only valid short and extra-long commands to address 001 are answered.
// - start condition is five missing syncs or 31 consecutive syncs.
// - a sync pulse is a one bit, a missing sync a zero bit.
`timescale 1ns/1ps
`default_nettype none
module psef_top
   import psef_pkg::*;
#(
   parameter int ENTRY_WINDOW_US = 100
) (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // sync slots seen on the supply line
   input wire logic sync_pulse,
   input wire logic sync_miss,
   // fault levels
   input wire logic flt_supply,
   input wire logic flt_comm,
   input wire logic flt_test,
   input wire logic flt_absolute_pressure_reading,
   input wire logic flt_temp,
   input wire logic flt_mem,
   input wire logic flt_selftest,
   input wire logic flt_block,
   input wire logic second_user_fuse_region,
   // decoded command from the decoder
   input wire logic cmd_valid,
   input wire logic cmd_ok,
   input wire psef_pkg::psef_cmd_t cmd_kind,
   input wire logic [2:0] cmd_addr,
   input wire logic cmd_entry,
   // response request toward the transmitter
   output logic resp_valid,
   output psef_pkg::psef_resp_t resp_kind,
   output logic [9:0] resp_code,
   // programming link status
   output logic cmd_start,
   output logic cmd_accept,
   output logic prog_mode,
   output logic entry_blocked,
   output logic init_done
);
   import psef_pkg::*;

   // ****************************************
   // entry window length
   // ****************************************
   localparam int WIN_CYCLES = ENTRY_WINDOW_US * NS_PER_US / CLK_PERIOD_NS;
   localparam logic [23:0] WIN_LAST = 24'(WIN_CYCLES - 1);

   psef_state_t state;
   psef_state_t next_state;
   logic [23:0] win_cnt;
   logic [4:0] ones_run;
   logic [4:0] zeros_run;
   logic start_ones;
   logic start_any;
   logic [3:0] frame_cnt;
   logic [NUM_RANKS-1:0] pend;

   // ****************************************
   // start condition tracking
   // ****************************************
   wire ones_full = (ones_run >= START_ONES);
   wire [4:0] zeros_inc = (zeros_run == RUN_MAX) ? RUN_MAX : zeros_run + RUN_STEP;
   wire [4:0] ones_inc = (ones_run == RUN_MAX) ? RUN_MAX : ones_run + RUN_STEP;
   wire [4:0] next_ones_run = sync_pulse ? ones_inc : (sync_miss ? 5'h00 : ones_run);
   wire [4:0] next_zeros_run = sync_miss ? zeros_inc : (sync_pulse ? 5'h00 : zeros_run);
   // first zero after a long run of ones is the leading start bit
   wire hit_ones = sync_miss & ones_full;
   wire hit_zeros = sync_miss & (zeros_inc == START_ZEROS) & (zeros_run != START_ZEROS);
   wire hit_start = hit_ones | hit_zeros;
   // set wins over the clear by a finished command
   wire next_start_ones = hit_ones | (start_ones & ~cmd_valid);
   wire next_start_any = hit_start | (start_any & ~cmd_valid);
   wire listen = (state == ST_WIN) | (state == ST_PROG);
   wire next_cmd_start = listen & hit_start;

   // ****************************************
   // entry and command acceptance
   // ****************************************
   wire win_end = (state == ST_WIN) & (win_cnt == WIN_LAST);
   wire entry_ok = (state == ST_WIN) & cmd_valid & cmd_ok & cmd_entry &
                   (cmd_kind == CMD_SHORT) & start_ones;
   wire kind_ok = (cmd_kind == CMD_SHORT) | (cmd_kind == CMD_EXTRA_LONG_FRAME);
   wire next_cmd_accept = (state == ST_PROG) & cmd_valid & cmd_ok & kind_ok &
                          (cmd_addr == PROG_ADDR) & start_any;
   wire [23:0] next_win_cnt = (state == ST_WIN) ? win_cnt + WIN_STEP : win_cnt;
   // a good entry on the last window cycle is not also blocked
   wire next_entry_blocked = entry_blocked | (win_end & ~entry_ok);
   wire next_prog_mode = prog_mode | entry_ok;

   // ****************************************
   // fault collection and priority
   // ****************************************
   wire [NUM_RANKS-1:0] flt_vec = {flt_comm, flt_absolute_pressure_reading, flt_temp,
                                   flt_mem, flt_test, flt_selftest};
   wire prio_hit;
   wire [2:0] prio_idx;
   psef_prio psef_prio_i (
      .pend(pend),
      .hit(prio_hit),
      .idx(prio_idx)
   );

   // supply fault means the sync is left unanswered
   wire answer = sync_pulse & ~flt_supply;
   wire adv = answer & ~flt_block;
   wire send_err = (state == ST_NORM) & answer & prio_hit;
   wire [NUM_RANKS-1:0] clr_vec = send_err ? (ONE_HOT_BASE << prio_idx) & ~LATCHED_MASK
                                           : 6'h00;
   // set wins over the clear of the frame just sent
   wire [NUM_RANKS-1:0] next_pend = (pend & ~clr_vec) | flt_vec;

   // ****************************************
   // phase sequencing
   // ****************************************
   wire cnt_last2 = (frame_cnt == PH2_LAST);
   wire cnt_last3 = (frame_cnt == PH3_LAST);

   always_comb begin
      next_state = state;
      case (state)
         ST_WIN: begin
            if (entry_ok) begin
               next_state = ST_PROG;
            end else if (win_end) begin
               next_state = ST_PH2;
            end
         end
         ST_PH2: begin
            if (adv && cnt_last2) begin
               next_state = ST_PH3;
            end
         end
         ST_PH3: begin
            if (adv && cnt_last3) begin
               next_state = ST_NORM;
            end
         end
         ST_NORM: next_state = ST_NORM;
         ST_PROG: next_state = ST_PROG;
         default: next_state = ST_WIN;
      endcase
   end

   wire state_move = (next_state != state);
   wire [3:0] next_frame_cnt = state_move ? 4'h0 : (adv ? frame_cnt + CNT_STEP : frame_cnt);

   // ****************************************
   // response selection
   // ****************************************
   wire in_init = (state == ST_PH2) | (state == ST_PH3);
   // programming mode never answers syncs with normal frames
   wire next_resp_valid = answer & (in_init | (state == ST_NORM));
   wire psef_resp_t ph3_kind = second_user_fuse_region ? RESP_READY
                                                       : RESP_READY_UNLOCKED;
   wire psef_resp_t norm_kind = prio_hit ? RESP_ERROR : RESP_DATA;
   wire psef_resp_t next_resp_kind = ~next_resp_valid ? RESP_NONE :
                                     (state == ST_PH2) ? RESP_PH2 :
                                     (state == ST_PH3) ? ph3_kind : norm_kind;
   wire [9:0] next_resp_code = send_err ? ERR_CODE[prio_idx] : CODE_NONE;

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_WIN;
         win_cnt <= 24'h000000;
         ones_run <= 5'h00;
         zeros_run <= 5'h00;
         start_ones <= 1'b0;
         start_any <= 1'b0;
         frame_cnt <= 4'h0;
         pend <= 6'h00;
      end else begin
         state <= next_state;
         win_cnt <= next_win_cnt;
         ones_run <= next_ones_run;
         zeros_run <= next_zeros_run;
         start_ones <= next_start_ones;
         start_any <= next_start_any;
         frame_cnt <= next_frame_cnt;
         pend <= next_pend;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         resp_valid <= 1'b0;
         resp_kind <= RESP_NONE;
         resp_code <= CODE_NONE;
         cmd_start <= 1'b0;
         cmd_accept <= 1'b0;
         prog_mode <= 1'b0;
         entry_blocked <= 1'b0;
         init_done <= 1'b0;
      end else begin
         resp_valid <= next_resp_valid;
         resp_kind <= next_resp_kind;
         resp_code <= next_resp_code;
         cmd_start <= next_cmd_start;
         cmd_accept <= next_cmd_accept;
         prog_mode <= next_prog_mode;
         entry_blocked <= next_entry_blocked;
         init_done <= (next_state == ST_NORM);
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   a_ph2_supply_quiet: assert property (
      (state == ST_PH2) && sync_pulse && flt_supply |=> !resp_valid)
      else $error("phase 2 answered a sync during supply fault");
   a_ph2_still_sends: assert property (
      (state == ST_PH2) && sync_pulse && !flt_supply && (flt_temp || flt_mem)
      |=> resp_valid && (resp_kind == RESP_PH2))
      else $error("phase 2 frame missing under temperature or memory fault");
   a_ph2_block_hold: assert property (
      (state == ST_PH2) && flt_block |=> (state == ST_PH2))
      else $error("left phase 2 while blocked");
   a_ph3_supply_quiet: assert property (
      (state == ST_PH3) && sync_pulse && flt_supply |=> !resp_valid)
      else $error("phase 3 answered a sync during supply fault");
   a_ph3_still_sends: assert property (
      (state == ST_PH3) && sync_pulse && !flt_supply |=> resp_valid ##0
      (resp_kind == RESP_READY || resp_kind == RESP_READY_UNLOCKED))
      else $error("phase 3 frame missing");
   a_run_after_ready: assert property (
      (state == ST_PH3) ##1 (state == ST_NORM) |-> resp_valid && !$past(flt_block))
      else $error("run mode entered without an unblocked ready frame");
   a_unlocked_ready: assert property (
      (state == ST_PH3) && answer && !second_user_fuse_region
      |=> (resp_kind == RESP_READY_UNLOCKED))
      else $error("unlocked device sent plain ready");
   a_comm_code: assert property (
      (state == ST_NORM) && answer && (pend == 6'h20) |=> (resp_code == CODE_COMM))
      else $error("communication fault code wrong");
   a_selftest_first: assert property (
      (state == ST_NORM) && answer && pend[RK_SELFTEST]
      |=> (resp_kind == RESP_ERROR) && (resp_code == CODE_SELFTEST))
      else $error("self-test fault not reported first");
   a_mem_latched: assert property (
      pend[RK_MEM] |=> pend[RK_MEM])
      else $error("memory fault dropped before reset");
   a_selftest_latched: assert property (
      pend[RK_SELFTEST] |=> pend[RK_SELFTEST])
      else $error("self-test fault dropped before reset");
   a_temp_clears: assert property (
      (state == ST_NORM) && answer && (pend == 6'h08) && !flt_temp ##1 !flt_temp
      |-> !pend[RK_TEMP])
      else $error("temporary fault not cleared by error frame");
   a_norm_supply: assert property (
      (state == ST_NORM) && sync_pulse && flt_supply |=> !resp_valid)
      else $error("normal mode answered during supply fault");
   a_entry_needs_run: assert property (
      $rose(prog_mode) |-> $past(start_ones) && $past(cmd_entry))
      else $error("programming entry without a sync run");
   a_entry_blocked: assert property (
      entry_blocked |=> entry_blocked && !$rose(prog_mode))
      else $error("programming entry after block");
   a_prog_silent: assert property (
      prog_mode |-> !resp_valid)
      else $error("normal frame in programming mode");
   a_accept_addr: assert property (
      cmd_accept |-> ($past(cmd_addr) == PROG_ADDR) && $past(start_any))
      else $error("command accepted for wrong address");

   c_enter_prog: cover property ($rose(prog_mode));
   c_reach_norm: cover property ($rose(init_done) ##[1:50] (resp_kind == RESP_ERROR));
   c_block_phase3: cover property ((state == ST_PH3) && flt_block ##1 (state == ST_PH3));
   c_prog_accept: cover property (cmd_accept);
endmodule
`default_nettype wire

// ==== psef_prio.sv ====
// Purpose: shared constants for the link supervisor and its fault priority picker
// Assumes: fault vector bit i holds the fault of priority rank i+1
// Notes: lowest set bit wins, bit 0 is the most urgent
`timescale 1ns/1ps
`default_nettype none
package psef_pkg;
   // ****************************************
   // timing and thresholds
   // ****************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int NS_PER_US = 1000;
   localparam int NUM_RANKS = 6;
   localparam logic [4:0] START_ONES = 5'h1F;
   localparam logic [4:0] START_ZEROS = 5'h05;
   localparam logic [4:0] RUN_MAX = 5'h1F;
   localparam logic [4:0] RUN_STEP = 5'h01;
   localparam logic [2:0] PROG_ADDR = 3'h1;
   localparam logic [3:0] PH2_LAST = 4'h7;
   localparam logic [3:0] PH3_LAST = 4'h1;
   localparam logic [3:0] CNT_STEP = 4'h1;
   localparam logic [23:0] WIN_STEP = 24'h000001;
   // ****************************************
   // fault ranks and codes
   // ****************************************
   localparam int RK_SELFTEST = 0;
   localparam int RK_TEST = 1;
   localparam int RK_MEM = 2;
   localparam int RK_TEMP = 3;
   localparam int RK_ABSOLUTE_PRESSURE_READING = 4;
   localparam int RK_COMM = 5;
   localparam logic [5:0] LATCHED_MASK = 6'h05;
   localparam logic [5:0] ONE_HOT_BASE = 6'h01;
   localparam logic [9:0] CODE_NONE = 10'h000;
   localparam logic [9:0] CODE_SELFTEST = 10'h1EA;
   localparam logic [9:0] CODE_MEM = 10'h1EB;
   localparam logic [9:0] CODE_TEMP = 10'h1EC;
   localparam logic [9:0] CODE_ABSOLUTE_PRESSURE_READING = 10'h1ED;
   localparam logic [9:0] CODE_TEST = 10'h1EE;
   localparam logic [9:0] CODE_COMM = 10'h1EF;
   localparam logic [9:0] ERR_CODE [8] = '{CODE_SELFTEST, CODE_TEST, CODE_MEM, CODE_TEMP,
                                           CODE_ABSOLUTE_PRESSURE_READING, CODE_COMM, CODE_NONE, CODE_NONE};
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      ST_WIN = 3'b000,
      ST_PH2 = 3'b001,
      ST_PH3 = 3'b010,
      ST_NORM = 3'b011,
      ST_PROG = 3'b100
   } psef_state_t;
   typedef enum logic [2:0] {
      RESP_NONE = 3'b000,
      RESP_PH2 = 3'b001,
      RESP_READY = 3'b010,
      RESP_READY_UNLOCKED = 3'b011,
      RESP_DATA = 3'b100,
      RESP_ERROR = 3'b101
   } psef_resp_t;
   typedef enum logic [1:0] {
      CMD_SHORT = 2'b00,
      CMD_LONG = 2'b01,
      CMD_EXTRA_LONG_FRAME = 2'b10,
      CMD_OTHER = 2'b11
   } psef_cmd_t;
endpackage

module psef_prio
   import psef_pkg::*;
(
   // pending faults, bit 0 most urgent
   input wire logic [NUM_RANKS-1:0] pend,
   // winner
   output logic hit,
   output logic [2:0] idx
);
   logic [NUM_RANKS:0] found;
   logic [2:0] acc [NUM_RANKS+1];
   assign found[0] = 1'b0;
   assign acc[0] = 3'h0;
   genvar i;
   generate
      for (i = 0; i < NUM_RANKS; i++) begin : g_rank
         wire sel = pend[i] & ~found[i];
         assign found[i+1] = found[i] | pend[i];
         assign acc[i+1] = acc[i] | (sel ? 3'(i) : 3'h0);
      end
   endgenerate
   assign hit = found[NUM_RANKS];
   assign idx = acc[NUM_RANKS];
endmodule
`default_nettype wire

// ==== psef_dummy_unused_never.sv ====
// Purpose: spare source, holds no logic
// Assumes: nothing
// Notes: all logic lives in psef_top.sv and psef_prio.sv

// ==== psef_rx_model.sv ====
// Purpose: receiver stand-in that drives sync slots and decoded command frames
// Assumes: everything changes at the falling edge of mclk
// Notes: GAP+1 idle cycles per slot stand for the programming sync period
`timescale 1ns/1ps
`default_nettype none
module psef_rx_model
   import psef_pkg::*;
#(
   parameter int GAP = 2
) (
   // clock
   input wire logic mclk,
   // sync slots
   output logic sync_pulse,
   output logic sync_miss,
   // decoded command
   output logic cmd_valid,
   output logic cmd_ok,
   output psef_pkg::psef_cmd_t cmd_kind,
   output logic [2:0] cmd_addr,
   output logic cmd_entry
);
   initial begin
      sync_pulse = 1'b0;
      sync_miss = 1'b0;
      cmd_valid = 1'b0;
      cmd_ok = 1'b0;
      cmd_kind = CMD_OTHER;
      cmd_addr = 3'h0;
      cmd_entry = 1'b0;
   end
   // ****************************************
   // n slots of one bit value each
   // ****************************************
   task automatic slot(input logic one, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge mclk);
         sync_pulse = one;
         sync_miss = !one;
         @(negedge mclk);
         sync_pulse = 1'b0;
         sync_miss = 1'b0;
         repeat (GAP) @(negedge mclk);
      end
   endtask
   // ****************************************
   // one decoded command, then fields scrambled
   // ****************************************
   task automatic send(input logic ok, input psef_cmd_t k, input logic [2:0] a, input logic e);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd_ok = ok;
      cmd_kind = k;
      cmd_addr = a;
      cmd_entry = e;
      @(negedge mclk);
      cmd_valid = 1'b0;
      cmd_ok = ~ok;
      cmd_kind = CMD_OTHER;
      cmd_addr = ~a;
      cmd_entry = ~e;
      repeat (GAP) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// ==== psef_top_tb.sv ====
// Purpose: self-checking bench for the link supervisor
// Assumes: inputs change at the falling edge of mclk
// Notes: entry window shortened to 1 us, 250 cycles
`timescale 1ns/1ps
`default_nettype none
module psef_top_tb;
   import psef_pkg::*;
   typedef struct packed {logic [5:0] f; logic [9:0] c1; logic [9:0] c2;} psef_row_t;
   logic mclk, sys_rst, sync_pulse, sync_miss, cmd_valid, cmd_ok, cmd_entry;
   logic flt_supply, flt_comm, flt_test, flt_absolute_pressure_reading, flt_temp, flt_mem, flt_selftest;
   logic flt_block, second_user_fuse_region, resp_valid, cmd_start, cmd_accept;
   logic prog_mode, entry_blocked, init_done;
   logic [2:0] cmd_addr;
   logic [9:0] resp_code, r_code;
   psef_cmd_t cmd_kind;
   psef_resp_t resp_kind, r_kind;
   int failures = 0;
   int samples_checked = 0;
   int n_resp = 0;
   int n_start = 0;
   int n_acc = 0;
   // fault order: comm, test, absolute_pressure_reading, temp, mem, selftest
   psef_row_t rows [7] = '{'{6'h20, CODE_COMM, CODE_NONE}, '{6'h10, CODE_TEST, CODE_NONE},
      '{6'h08, CODE_ABSOLUTE_PRESSURE_READING, CODE_NONE}, '{6'h04, CODE_TEMP, CODE_NONE},
      '{6'h3C, CODE_TEST, CODE_TEMP}, '{6'h02, CODE_MEM, CODE_MEM},
      '{6'h03, CODE_SELFTEST, CODE_SELFTEST}};
   psef_top #(.ENTRY_WINDOW_US(1)) psef_top_i (.mclk(mclk), .sys_rst(sys_rst),
      .sync_pulse(sync_pulse), .sync_miss(sync_miss), .flt_supply(flt_supply),
      .flt_comm(flt_comm), .flt_test(flt_test), .flt_absolute_pressure_reading(flt_absolute_pressure_reading), .flt_temp(flt_temp),
      .flt_mem(flt_mem), .flt_selftest(flt_selftest), .flt_block(flt_block),
      .second_user_fuse_region(second_user_fuse_region), .cmd_valid(cmd_valid),
      .cmd_ok(cmd_ok), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_entry(cmd_entry),
      .resp_valid(resp_valid), .resp_kind(resp_kind), .resp_code(resp_code),
      .cmd_start(cmd_start), .cmd_accept(cmd_accept), .prog_mode(prog_mode),
      .entry_blocked(entry_blocked), .init_done(init_done));
   psef_rx_model rx_i (.mclk(mclk), .sync_pulse(sync_pulse), .sync_miss(sync_miss),
      .cmd_valid(cmd_valid), .cmd_ok(cmd_ok), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
      .cmd_entry(cmd_entry));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // ****************************************
   // pulse monitor
   // ****************************************
   always @(negedge mclk) begin
      if (resp_valid === 1'b1) begin
         n_resp++;
         r_kind = resp_kind;
         r_code = resp_code;
      end
      if (cmd_start === 1'b1) n_start++;
      if (cmd_accept === 1'b1) n_acc++;
   end
   // ****************************************
   // compare, wait and report tasks
   // ****************************************
   task automatic chk_flag(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_frame(input logic [12:0] got, input logic [12:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wait_for(input int w);
      for (int i = 0; i < 300; i++) begin
         if ((w == 0 ? prog_mode : entry_blocked) === 1'b1) return;
         @(negedge mclk);
      end
      chk_flag(1'b0, 1'b1);
      wrap_up();
   endtask
   task automatic do_reset();
      sys_rst = 1'b1;
      {flt_supply, flt_comm, flt_test, flt_absolute_pressure_reading, flt_temp, flt_mem} = 6'h00;
      {flt_selftest, flt_block} = 2'h0;
      repeat (3) @(negedge mclk);
      chk_flag(resp_valid | cmd_start | cmd_accept | prog_mode | entry_blocked | init_done, 1'b0);
      chk_frame({resp_kind, resp_code}, {RESP_NONE, CODE_NONE});
      sys_rst = 1'b0;
   endtask
   task automatic sync_chk(input logic ans, input psef_resp_t k, input logic [9:0] c);
      int b;
      b = n_resp;
      rx_i.slot(1'b1, 1);
      chk_flag(n_resp == b + 1, ans);
      if (ans) chk_frame({r_kind, r_code}, {k, c});
   endtask
   task automatic acc_chk(input logic st, ok, input psef_cmd_t k, input logic [2:0] a,
                          input logic e);
      int b;
      // a one ends the last zero run, as response syncs would
      rx_i.slot(1'b1, 1);
      b = n_start;
      if (st) rx_i.slot(1'b0, 5);
      chk_flag(n_start == b + 1, st);
      b = n_acc;
      rx_i.send(ok, k, a, 1'b0);
      chk_flag(n_acc == b + 1, e);
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      chk_flag(1'b0, 1'b1);
      wrap_up();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int b;
      sys_rst = 1'b1;
      second_user_fuse_region = 1'b0;
      do_reset();
      rx_i.slot(1'b1, 31);
      b = n_start;
      rx_i.slot(1'b0, 1);
      chk_flag(n_start == b + 1, 1'b1);
      rx_i.send(1'b1, CMD_SHORT, PROG_ADDR, 1'b1);
      wait_for(0);
      sync_chk(1'b0, RESP_NONE, CODE_NONE);
      acc_chk(1'b1, 1'b1, CMD_SHORT, PROG_ADDR, 1'b1);
      acc_chk(1'b1, 1'b1, CMD_EXTRA_LONG_FRAME, PROG_ADDR, 1'b1);
      acc_chk(1'b1, 1'b1, CMD_LONG, PROG_ADDR, 1'b0);
      acc_chk(1'b1, 1'b1, CMD_OTHER, PROG_ADDR, 1'b0);
      acc_chk(1'b1, 1'b1, CMD_SHORT, 3'h2, 1'b0);
      acc_chk(1'b1, 1'b0, CMD_EXTRA_LONG_FRAME, PROG_ADDR, 1'b0);
      acc_chk(1'b0, 1'b1, CMD_SHORT, PROG_ADDR, 1'b0);
      chk_flag(entry_blocked, 1'b0);
      do_reset();
      flt_temp = 1'b1;
      rx_i.slot(1'b1, 30);
      rx_i.slot(1'b0, 1);
      rx_i.send(1'b1, CMD_SHORT, PROG_ADDR, 1'b1);
      wait_for(1);
      chk_flag(prog_mode, 1'b0);
      sync_chk(1'b1, RESP_PH2, CODE_NONE);
      flt_supply = 1'b1;
      sync_chk(1'b0, RESP_NONE, CODE_NONE);
      flt_supply = 1'b0;
      flt_block = 1'b1;
      repeat (3) sync_chk(1'b1, RESP_PH2, CODE_NONE);
      flt_block = 1'b0;
      flt_temp = 1'b0;
      repeat (7) sync_chk(1'b1, RESP_PH2, CODE_NONE);
      flt_temp = 1'b1;
      sync_chk(1'b1, RESP_READY_UNLOCKED, CODE_NONE);
      flt_temp = 1'b0;
      flt_supply = 1'b1;
      sync_chk(1'b0, RESP_NONE, CODE_NONE);
      flt_supply = 1'b0;
      flt_block = 1'b1;
      sync_chk(1'b1, RESP_READY_UNLOCKED, CODE_NONE);
      chk_flag(init_done, 1'b0);
      flt_block = 1'b0;
      sync_chk(1'b1, RESP_READY_UNLOCKED, CODE_NONE);
      chk_flag(init_done, 1'b1);
      sync_chk(1'b1, RESP_ERROR, CODE_TEMP);
      sync_chk(1'b1, RESP_DATA, CODE_NONE);
      flt_supply = 1'b1;
      sync_chk(1'b0, RESP_NONE, CODE_NONE);
      flt_supply = 1'b0;
      sync_chk(1'b1, RESP_DATA, CODE_NONE);
      for (int i = 0; i < 7; i++) begin
         {flt_comm, flt_test, flt_absolute_pressure_reading, flt_temp, flt_mem, flt_selftest} = rows[i].f;
         @(negedge mclk);
         {flt_comm, flt_test, flt_absolute_pressure_reading, flt_temp, flt_mem, flt_selftest} = 6'h00;
         sync_chk(1'b1, RESP_ERROR, rows[i].c1);
         sync_chk(1'b1, rows[i].c2 == CODE_NONE ? RESP_DATA : RESP_ERROR, rows[i].c2);
      end
      do_reset();
      second_user_fuse_region = 1'b1;
      wait_for(1);
      repeat (8) sync_chk(1'b1, RESP_PH2, CODE_NONE);
      sync_chk(1'b1, RESP_READY, CODE_NONE);
      rx_i.slot(1'b1, 31);
      rx_i.slot(1'b0, 1);
      rx_i.send(1'b1, CMD_SHORT, PROG_ADDR, 1'b1);
      repeat (4) @(negedge mclk);
      chk_flag(prog_mode, 1'b0);
      chk_flag(init_done, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
